//--- core/dsi_sram_dev.sv
// Memory end: separate-port DDR SRAM array behind sampled pins
// Functional notes
// - x8 part writes only selected nibbles
// - Lane selects share the data's clock edge
// - Deselected nibble data never stored
// - Byte selects sampled on both input clocks
// - Unselected bytes keep previous contents
// - Read address on k, write on k_n
// - Two arrays; address 22/21/20 bits by width
// - Address ignored while its port is deselected
// - Read data on output clocks, or k
// - Deselected read port floats its outputs
// - Read select sampled on k starts read
// - Pending burst finishes, float after next c
// - Each read is four transfers
// - Controller drives complementary output clocks
// - Accesses begin on a k rising edge
// - k_n also captures; single mode launches
// - Write select on k; ignore deselected data
// - Write data taken on both input edges
module dsi_sram_dev #(
    parameter int DW = dsi_pkg::DATA_W_X36,
    parameter int AW = dsi_pkg::ADDR_W_X36
) (
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic single_clk_mode_i,
    dsi_link_if.dev   link
);
    // Lane geometry from the data width
    localparam int LANES = dsi_pkg::lane_count(DW);
    localparam int LW    = dsi_pkg::lane_width(DW);
    // Words per array: two per address, one per half of the burst
    localparam int DEPTH = 2 ** (AW + 1);

    // One sampled copy of every input pin
    typedef struct packed {
        logic             k;
        logic             k_n;
        logic             c;
        logic             c_n;
        logic [AW-1:0]    addr;
        logic             rps_n;
        logic             wps_n;
        logic [LANES-1:0] sel_n;
        logic [DW-1:0]    d;
    } dsi_pin_type;

    // All state of the memory end
    typedef struct packed {
        dsi_pin_type      s1;       // First synchroniser stage
        dsi_pin_type      s2;       // Second synchroniser stage
        logic             k_p;      // Previous clock levels
        logic             kn_p;
        logic             c_p;
        logic             cn_p;
        logic             rd_pend;  // Read taken, burst not yet started
        logic [AW-1:0]    rd_addr;  // Latched read address
        logic             rd_act;   // Burst on the outputs
        logic [1:0]       rd_beat;  // Next beat to launch
        logic             wr_act;   // Write burst being collected
        logic [1:0]       wr_beat;  // Next beat to accept
        logic [AW-1:0]    wr_addr;  // Latched write address
        logic [DW-1:0]    wr_d0;    // First beat, held for the address
        logic [LANES-1:0] wr_sel0;  // Its lane selects
        logic [DW-1:0]    q;        // Read data register
        logic             q_oe_n;   // Output drive, low drives
    } dsi_dev_type;

    // Pin stages come up with the selects idle
    localparam dsi_pin_type PIN_RST = '{
        rps_n: dsi_pkg::SEL_IDLE,
        wps_n: dsi_pkg::SEL_IDLE,
        sel_n: '1,
        default: '0
    };
    // Outputs float from reset onward
    localparam dsi_dev_type DEV_RST = '{
        s1: PIN_RST,
        s2: PIN_RST,
        q_oe_n: 1'b1,
        default: '0
    };

    dsi_dev_type     st;           // Registered state
    dsi_dev_type     next_st;      // Next state
    logic            k_rise;       // Edge strobes of sampled clocks
    logic            kn_rise;
    logic            oc_rise;      // Output launch edges
    logic            ocn_rise;
    logic            we0;          // Array 0 write strobe
    logic            we1;          // Array 1 write strobe
    logic [AW:0]     idx0;         // Array 0 word index
    logic [AW:0]     idx1;         // Array 1 word index
    logic [DW-1:0]   wd0;          // Array 0 write word
    logic [DW-1:0]   wd1;          // Array 1 write word
    logic [LANES-1:0] ws0_n;       // Array 0 lane selects
    logic [LANES-1:0] ws1_n;       // Array 1 lane selects

    // Even beats live in one array, odd beats in the other
    logic [DW-1:0] arr0 [DEPTH];
    logic [DW-1:0] arr1 [DEPTH];

    // Next state of the whole memory end
    always_comb
    begin
        next_st = st;
        // Every pin passes two stages before use
        next_st.s1.k     = link.k;
        next_st.s1.k_n   = link.k_n;
        next_st.s1.c     = link.c;
        next_st.s1.c_n   = link.c_n;
        next_st.s1.addr  = link.addr;
        next_st.s1.rps_n = link.read_port_sel_n;
        next_st.s1.wps_n = link.write_port_sel_n;
        next_st.s1.sel_n = link.byte_write_sel_n;
        next_st.s1.d     = link.d;
        next_st.s2       = st.s1;
        next_st.k_p      = st.s2.k;
        next_st.kn_p     = st.s2.k_n;
        next_st.c_p      = st.s2.c;
        next_st.cn_p     = st.s2.c_n;
        // Only rising edges matter on any clock
        k_rise  = st.s2.k & ~st.k_p;
        kn_rise = st.s2.k_n & ~st.kn_p;
        // Single mode borrows the input clocks for launch
        if (single_clk_mode_i)
        begin
            oc_rise  = k_rise;
            ocn_rise = kn_rise;
        end
        else
        begin
            oc_rise  = st.s2.c & ~st.c_p;
            ocn_rise = st.s2.c_n & ~st.cn_p;
        end
        we0   = 1'b0;
        we1   = 1'b0;
        idx0  = '0;
        idx1  = '0;
        wd0   = '0;
        wd1   = '0;
        ws0_n = '1;
        ws1_n = '1;

        // Read command: one slot; a busy slot ignores the select
        if (k_rise && !st.s2.rps_n && !st.rd_pend)
        begin
            next_st.rd_pend = 1'b1;
            // Address only taken for a selected port
            next_st.rd_addr = st.s2.addr;
        end

        // Positive launch edge: beats 0 and 2
        if (oc_rise)
        begin
            if (st.rd_act && st.rd_beat == 2'h2)
            begin
                next_st.q       = arr0[{st.rd_addr, 1'b1}];
                next_st.rd_beat = 2'h3;
            end
            else if (st.rd_pend)
            begin
                next_st.q       = arr0[{st.rd_addr, 1'b0}];
                next_st.q_oe_n  = 1'b0;
                next_st.rd_act  = 1'b1;
                next_st.rd_beat = 2'h1;
                next_st.rd_pend = 1'b0;
            end
            else
            begin
                // Nothing left: float after this edge
                next_st.q_oe_n = 1'b1;
            end
        end

        // Negative launch edge: beats 1 and 3
        if (ocn_rise && st.rd_act)
        begin
            if (st.rd_beat == 2'h1)
            begin
                next_st.q       = arr1[{st.rd_addr, 1'b0}];
                next_st.rd_beat = 2'h2;
            end
            else if (st.rd_beat == 2'h3)
            begin
                // Last beat stays until the next positive edge
                next_st.q       = arr1[{st.rd_addr, 1'b1}];
                next_st.rd_act  = 1'b0;
                next_st.rd_beat = 2'h0;
            end
        end

        // Write side has its own state; reads never touch it
        if (k_rise)
        begin
            if (st.wr_act && st.wr_beat == 2'h2)
            begin
                // Third beat with the selects of the same edge
                we0   = 1'b1;
                idx0  = {st.wr_addr, 1'b1};
                wd0   = st.s2.d;
                ws0_n = st.s2.sel_n;
                next_st.wr_beat = 2'h3;
            end
            else if (!st.wr_act && !st.s2.wps_n)
            begin
                // First beat held until the address arrives
                next_st.wr_act  = 1'b1;
                next_st.wr_beat = 2'h1;
                next_st.wr_d0   = st.s2.d;
                next_st.wr_sel0 = st.s2.sel_n;
            end
        end

        // Negative input edge: address, then odd beats
        if (kn_rise && st.wr_act)
        begin
            if (st.wr_beat == 2'h1)
            begin
                next_st.wr_addr = st.s2.addr;
                we0   = 1'b1;
                idx0  = {st.s2.addr, 1'b0};
                wd0   = st.wr_d0;
                ws0_n = st.wr_sel0;
                we1   = 1'b1;
                idx1  = {st.s2.addr, 1'b0};
                wd1   = st.s2.d;
                ws1_n = st.s2.sel_n;
                next_st.wr_beat = 2'h2;
            end
            else if (st.wr_beat == 2'h3)
            begin
                we1   = 1'b1;
                idx1  = {st.wr_addr, 1'b1};
                wd1   = st.s2.d;
                ws1_n = st.s2.sel_n;
                next_st.wr_act  = 1'b0;
                next_st.wr_beat = 2'h0;
            end
        end
    end

    // State register
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            st <= DEV_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Lane-masked array writes; no reset, contents are undefined
    always_ff @(posedge clk_i)
    begin
        for (int l = 0; l < LANES; l++)
        begin
            // Lanes with a high select are left untouched
            if (we0 && !ws0_n[l])
            begin
                arr0[idx0][l*LW +: LW] <= wd0[l*LW +: LW];
            end
            if (we1 && !ws1_n[l])
            begin
                arr1[idx1][l*LW +: LW] <= wd1[l*LW +: LW];
            end
        end
    end

    // Pins straight from the state register
    assign link.q      = st.q;
    assign link.q_oe_n = st.q_oe_n;
endmodule : dsi_sram_dev

//--- core/dsi_pkg.sv
// Shared constants of the separate-port DDR SRAM link
package dsi_pkg;
    // Data widths of the four device variants
    localparam int DATA_W_X8  = 8;
    localparam int DATA_W_X9  = 9;
    localparam int DATA_W_X18 = 18;
    localparam int DATA_W_X36 = 36;
    // Address widths of the four device variants
    localparam int ADDR_W_X8  = 22;
    localparam int ADDR_W_X9  = 22;
    localparam int ADDR_W_X18 = 21;
    localparam int ADDR_W_X36 = 20;
    // Transfers per access
    localparam int BURST_LEN  = 4;
    // Write lane widths: nibbles on the 8-bit part, bytes otherwise
    localparam int NIBBLE_W   = 4;
    localparam int BYTE_W     = 9;
    // System clock period
    localparam int CLK_PERIOD_NS = 4;
    // Link clock period as a count of system clock cycles
    localparam int LINK_PERIOD_NS  = 32;
    localparam int LINK_PERIOD_CYC = LINK_PERIOD_NS / CLK_PERIOD_NS;
    // Phases of the link period, counted by the controller
    localparam logic [2:0] PH_KN_RISE   = 3'h4;
    localparam logic [2:0] PH_LAUNCH_KN = 3'h2;
    localparam logic [2:0] PH_LAUNCH_K  = 3'h6;
    // Half-period ticks from read launch to the first returned beat
    localparam int RD_RET_TICK = 3;
    localparam int RD_SR_LEN   = 8;
    // Idle level of the active-low selects
    localparam logic SEL_IDLE = 1'b1;

    // Number of write select lanes for a data width
    function automatic int lane_count(input int dw);
        return (dw == DATA_W_X8) ? 2 : dw / BYTE_W;
    endfunction : lane_count

    // Width of one write select lane
    function automatic int lane_width(input int dw);
        return (dw == DATA_W_X8) ? NIBBLE_W : BYTE_W;
    endfunction : lane_width
endpackage : dsi_pkg

//--- core/dsi_link_if.sv
// Pin bundle between the memory controller and the SRAM device
interface dsi_link_if #(
    parameter int DW    = 36,
    parameter int AW    = 20,
    parameter int LANES = 4
);
    logic             k;                // Positive input clock
    logic             k_n;              // Negative input clock
    logic             c;                // Positive output clock
    logic             c_n;              // Negative output clock
    logic [AW-1:0]    addr;             // Shared read/write address
    logic             read_port_sel_n;  // Read port select, low active
    logic             write_port_sel_n; // Write port select, low active
    logic [LANES-1:0] byte_write_sel_n; // Lane selects (nibbles on x8)
    logic [DW-1:0]    d;                // Write data
    logic [DW-1:0]    q;                // Read data
    logic             q_oe_n;           // Read data enable, low drives

    // Memory end
    modport dev (
        input  k, k_n, c, c_n, addr, read_port_sel_n, write_port_sel_n,
        input  byte_write_sel_n, d,
        output q, q_oe_n
    );

    // Controller end
    modport ctl (
        output k, k_n, c, c_n, addr, read_port_sel_n, write_port_sel_n,
        output byte_write_sel_n, d,
        input  q, q_oe_n
    );
endinterface : dsi_link_if

//--- core/dsi_sram_ctl.sv
// Controller end: makes link clocks, issues bursts, collects reads
module dsi_sram_ctl #(
    parameter int DW = dsi_pkg::DATA_W_X36,
    parameter int AW = dsi_pkg::ADDR_W_X36
) (
    input  wire logic                   clk_i,
    input  wire logic                   sys_rst_i,
    input  wire logic                   rd_req_i,
    input  wire logic [AW-1:0]          rd_addr_i,
    output logic                        rd_ready_o,
    output logic                        rd_valid_o,
    output logic [4*DW-1:0]             rd_data_o,
    input  wire logic                   wr_req_i,
    input  wire logic [AW-1:0]          wr_addr_i,
    input  wire logic [4*DW-1:0]        wr_data_i,
    input  wire logic [4*dsi_pkg::lane_count(DW)-1:0] wr_sel_n_i,
    output logic                        wr_ready_o,
    output logic                        wr_busy_o,
    dsi_link_if.ctl                     link
);
    localparam int LANES = dsi_pkg::lane_count(DW);

    // All state of the controller end
    typedef struct packed {
        logic [2:0]         ph;        // Phase within the link period
        logic               k;         // Clock pins
        logic               k_n;
        logic               c;
        logic               c_n;
        logic [AW-1:0]      addr;      // Shared address pin
        logic               rps_n;
        logic               wps_n;
        logic [LANES-1:0]   sel_n;
        logic [DW-1:0]      d;
        logic               rd_slot;   // Read waiting for launch
        logic [AW-1:0]      rd_a;
        logic               rd_last;   // Read launched last period
        logic               wr_slot;   // Write waiting for launch
        logic [AW-1:0]      wr_a;
        logic [4*DW-1:0]    wr_dat;
        logic [4*LANES-1:0] wr_sel;
        logic               wr_act;    // Write burst on the pins
        logic [1:0]         wr_beat;
        logic [DW-1:0]      qs1;       // Read data synchroniser
        logic [DW-1:0]      qs2;
        logic [dsi_pkg::RD_SR_LEN-1:0] sr; // Launches in flight
        logic [3*DW-1:0]    rbuf;      // Beats 0..2 of a read
        logic               rd_valid;
        logic [4*DW-1:0]    rd_data;
        logic               rd_ready;
        logic               wr_ready;
    } dsi_ctl_type;

    // Selects idle, ports ready after reset
    localparam dsi_ctl_type CTL_RST = '{
        rps_n: dsi_pkg::SEL_IDLE,
        wps_n: dsi_pkg::SEL_IDLE,
        sel_n: '1,
        rd_ready: 1'b1,
        wr_ready: 1'b1,
        default: '0
    };

    dsi_ctl_type st;       // Registered state
    dsi_ctl_type next_st;  // Next state
    localparam int RT = dsi_pkg::RD_RET_TICK;

    // Next state of the controller end
    always_comb
    begin
        next_st = st;
        next_st.rd_valid = 1'b0;
        next_st.ph = 3'(st.ph + 3'h1);
        // Both pairs complementary, output pair aligned to input pair
        next_st.k   = (next_st.ph < dsi_pkg::PH_KN_RISE);
        next_st.k_n = ~next_st.k;
        next_st.c   = next_st.k;
        next_st.c_n = ~next_st.k;
        // Read data is a foreign pin: two stages
        next_st.qs1 = link.q;
        next_st.qs2 = st.qs1;

        // Quarter before k: read command, write start or beat 2
        if (st.ph == dsi_pkg::PH_LAUNCH_K)
        begin
            next_st.rps_n   = 1'b1;
            next_st.rd_last = 1'b0;
            // Reads at most every other period
            if (st.rd_slot && !st.rd_last)
            begin
                next_st.rps_n   = 1'b0;
                next_st.addr    = st.rd_a;
                next_st.rd_slot = 1'b0;
                next_st.rd_last = 1'b1;
            end
            next_st.wps_n = 1'b1;
            if (st.wr_act)
            begin
                next_st.d       = st.wr_dat[2*DW +: DW];
                next_st.sel_n   = st.wr_sel[2*LANES +: LANES];
                next_st.wr_beat = 2'h3;
            end
            else if (st.wr_slot)
            begin
                next_st.wps_n   = 1'b0;
                next_st.d       = st.wr_dat[DW-1:0];
                next_st.sel_n   = st.wr_sel[LANES-1:0];
                next_st.wr_act  = 1'b1;
                next_st.wr_beat = 2'h1;
                next_st.wr_slot = 1'b0;
            end
        end

        // Quarter before k_n: write address and odd beats
        if (st.ph == dsi_pkg::PH_LAUNCH_KN && st.wr_act)
        begin
            if (st.wr_beat == 2'h1)
            begin
                next_st.addr    = st.wr_a;
                next_st.d       = st.wr_dat[DW +: DW];
                next_st.sel_n   = st.wr_sel[LANES +: LANES];
                next_st.wr_beat = 2'h2;
            end
            else
            begin
                next_st.d       = st.wr_dat[3*DW +: DW];
                next_st.sel_n   = st.wr_sel[3*LANES +: LANES];
                next_st.wr_act  = 1'b0;
            end
        end

        // Half-period ticks collect returning beats
        if (st.ph == dsi_pkg::PH_LAUNCH_K || st.ph == dsi_pkg::PH_LAUNCH_KN)
        begin
            next_st.sr = {st.sr[dsi_pkg::RD_SR_LEN-2:0],
                          (st.ph == dsi_pkg::PH_LAUNCH_K) && !next_st.rps_n};
            if (st.sr[RT])
                next_st.rbuf[0 +: DW] = st.qs2;
            if (st.sr[RT+1])
                next_st.rbuf[DW +: DW] = st.qs2;
            if (st.sr[RT+2])
                next_st.rbuf[2*DW +: DW] = st.qs2;
            if (st.sr[RT+3])
            begin
                next_st.rd_valid = 1'b1;
                next_st.rd_data  = {st.qs2, st.rbuf};
            end
        end

        // User requests fill empty slots
        if (rd_req_i && !st.rd_slot)
        begin
            next_st.rd_slot = 1'b1;
            next_st.rd_a    = rd_addr_i;
        end
        if (wr_req_i && !st.wr_slot)
        begin
            next_st.wr_slot = 1'b1;
            next_st.wr_a    = wr_addr_i;
            next_st.wr_dat  = wr_data_i;
            next_st.wr_sel  = wr_sel_n_i;
        end
        next_st.rd_ready = ~next_st.rd_slot;
        next_st.wr_ready = ~next_st.wr_slot;
    end

    // State register
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            st <= CTL_RST;
        else
            st <= next_st;
    end

    // Pins and user outputs straight from the state register
    assign link.k                = st.k;
    assign link.k_n              = st.k_n;
    assign link.c                = st.c;
    assign link.c_n              = st.c_n;
    assign link.addr             = st.addr;
    assign link.read_port_sel_n  = st.rps_n;
    assign link.write_port_sel_n = st.wps_n;
    assign link.byte_write_sel_n = st.sel_n;
    assign link.d                = st.d;
    assign rd_ready_o            = st.rd_ready;
    assign rd_valid_o            = st.rd_valid;
    assign rd_data_o             = st.rd_data;
    assign wr_ready_o            = st.wr_ready;
    assign wr_busy_o             = st.wr_act;
endmodule : dsi_sram_ctl

//--- bench/dsi_link_monitor.sv
// Concurrent checks on the link pins between controller and memory
module dsi_link_monitor #(
    parameter int DW = 8
) (
    input  wire logic          clk_i,
    input  wire logic          sys_rst_i,
    input  wire logic          k,
    input  wire logic          c,
    input  wire logic          c_n,
    input  wire logic          read_port_sel_n,
    input  wire logic          write_port_sel_n,
    input  wire logic [DW-1:0] q,
    input  wire logic          q_oe_n
);
    logic [5:0] since_rd;  // Cycles since read port last selected

    // Saturating counter; bounds how long q may drive after a read
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            since_rd <= 6'h3f;
        else if (!read_port_sel_n)
            since_rd <= 6'h00;
        else if (since_rd != 6'h3f)
            since_rd <= since_rd + 6'h01;
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    property p_k_period;
        // First period after reset is one cycle short, so it is skipped
        $rose(k) && !$past(sys_rst_i, 2) |-> ##8 $rose(k);
    endproperty
    a_k_period: assert property (p_k_period) else $error("k period wrong");
    property p_c_pair;
        !(c && c_n);
    endproperty
    a_c_pair: assert property (p_c_pair) else $error("c pair overlap");
    property p_rd_sel;
        $fell(read_port_sel_n) |-> ##[1:8] ($rose(k) && !read_port_sel_n);
    endproperty
    a_rd_sel: assert property (p_rd_sel) else $error("read select misses k");
    property p_wr_sel;
        $fell(write_port_sel_n) |-> ##[1:8] ($rose(k) && !write_port_sel_n);
    endproperty
    a_wr_sel: assert property (p_wr_sel) else $error("write select misses k");
    property p_burst;
        $fell(q_oe_n) |-> !q_oe_n [*8] ##1 !q_oe_n [*8];
    endproperty
    a_burst: assert property (p_burst) else $error("read burst short");
    property p_float_c;
        $rose(q_oe_n) |-> ($past(c, 3) && !$past(c, 4)) || ($past(c, 2) && !$past(c, 3));
    endproperty
    a_float_c: assert property (p_float_c) else $error("float not after c");
    property p_float_idle;
        !q_oe_n |-> since_rd < 6'h28;
    endproperty
    a_float_idle: assert property (p_float_idle) else $error("q driven while idle");
    property p_q_on_c;
        $changed(q) && !q_oe_n |-> $past(c, 3) != $past(c, 4) || $past(c, 2) != $past(c, 3);
    endproperty
    a_q_on_c: assert property (p_q_on_c) else $error("q moved off c edge");

    // Main traffic seen on the pins
    c_read: cover property ($rose(q_oe_n));
    c_write: cover property ($fell(write_port_sel_n));
    c_both: cover property ($fell(read_port_sel_n) ##[0:8] !write_port_sel_n);
endmodule : dsi_link_monitor

//--- bench/tb.sv
// Self-checking bench joining controller and memory over the link
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        rd_req_i;          // User read request
    logic [2:0]  rd_addr_i;         // User read address
    logic        wr_req_i;          // User write request
    logic [2:0]  wr_addr_i;         // User write address
    logic [31:0] wr_data_i;         // Four write beats, beat 0 low
    logic [7:0]  wr_sel_n_i;        // Lane selects, low writes
    logic        single_clk_mode_i; // Launch read data on input clocks
    logic        rd_ready_o, rd_valid_o, wr_ready_o, wr_busy_o;
    logic [31:0] rd_data_o;
    logic [31:0] r;            // Random draw
    logic [7:0]  mem [0:31];   // Reference array, index {addr, beat}
    int          fails = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          seed = 5;

    dsi_link_if #(.DW(8), .AW(3), .LANES(2)) lnk ();
    // Nibble-lane part, tiny address so the array stays small
    dsi_sram_dev #(.DW(8), .AW(3)) dsi_sram_dev_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .single_clk_mode_i(single_clk_mode_i), .link(lnk.dev));
    dsi_sram_ctl #(.DW(8), .AW(3)) dsi_sram_ctl_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .rd_req_i(rd_req_i), .rd_addr_i(rd_addr_i), .rd_ready_o(rd_ready_o),
        .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .wr_req_i(wr_req_i),
        .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .wr_sel_n_i(wr_sel_n_i),
        .wr_ready_o(wr_ready_o), .wr_busy_o(wr_busy_o), .link(lnk.ctl));
    dsi_link_monitor #(.DW(8)) dsi_link_monitor_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .k(lnk.k), .c(lnk.c), .c_n(lnk.c_n), .read_port_sel_n(lnk.read_port_sel_n),
        .write_port_sel_n(lnk.write_port_sel_n), .q(lnk.q), .q_oe_n(lnk.q_oe_n));

    always #2 clk_i = ~clk_i;

    // Expected read word from the reference array
    function automatic logic [31:0] exp_word(input logic [2:0] a);
        return {mem[{a, 2'h3}], mem[{a, 2'h2}], mem[{a, 2'h1}], mem[{a, 2'h0}]};
    endfunction : exp_word

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict

    // Read and write issued together; the ports must not disturb each other
    task automatic op(input logic [2:0] ra, input logic [2:0] wa, input logic [31:0] dat,
                      input logic [7:0] sel, input bit chk);
        logic [31:0] exp;
        exp = exp_word(ra);
        rd_addr_i  <= ra;
        wr_addr_i  <= wa;
        wr_data_i  <= dat;
        wr_sel_n_i <= sel;
        rd_req_i   <= 1'b1;
        wr_req_i   <= 1'b1;
        @(posedge clk_i);
        rd_req_i <= 1'b0;
        wr_req_i <= 1'b0;
        // Both slots filled by the taken request
        @(negedge clk_i);
        check("ready_taken", 32'h0, {30'h0, rd_ready_o, wr_ready_o});
        while (rd_valid_o !== 1'b1) @(negedge clk_i);
        if (chk)
            check("rd_data_o", exp, rd_data_o);
        while (wr_busy_o !== 1'b0) @(negedge clk_i);
        // Margin for the memory's input pipeline before the next read
        repeat (24) @(posedge clk_i);
        for (int b = 0; b < 8; b++)
            if (!sel[b])
                mem[{wa, b[2:1]}][b[0]*4+:4] = dat[b*4+:4];
        check("q_oe_n", 32'h1, {31'h0, lnk.q_oe_n});
        // Slots empty again once both bursts have launched
        check("ready_idle", 32'h3, {30'h0, rd_ready_o, wr_ready_o});
    endtask : op

    // Hang guard, well above the longest expected run
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            print_verdict();
        end
    end

    initial
    begin
        // Inputs idle while reset is held
        rd_req_i          <= 1'b0;
        rd_addr_i         <= 3'h0;
        wr_req_i          <= 1'b0;
        wr_addr_i         <= 3'h0;
        wr_data_i         <= 32'h0;
        wr_sel_n_i        <= 8'hff;
        single_clk_mode_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        // Fill every word with a full write; reads here are unchecked, all but the last see undefined data
        for (int a = 0; a < 8; a++)
            op(3'(a + 1), 3'(a), $random(seed), 8'h00, 1'b0);
        $display("fill test done");
        // First writes select no lane, then odd lanes only, then random lanes
        for (int i = 0; i < 40; i++)
        begin
            r = $random(seed);
            // Launch source drawn per op; changed only while the link is idle
            single_clk_mode_i <= r[5];
            op(r[2:0], r[2:0] + {1'b0, r[4:3]} + 3'h1, $random(seed),
               i < 2 ? 8'hff : (i < 4 ? 8'h55 : r[15:8]), 1'b1);
        end
        $display("random test done");
        print_verdict();
    end
endmodule : tb
